// ---- rtl/rcs_top.sv ----
// rds content scheduler: station-name messages, af lists, pi/pty/flags
// assumes apb3 master, sec_tick_in one pulse per second, minute of day
// Functional notes
// - eight station-name messages, each with activate, timed, scroll, start, stop
// - activated timed message goes out only inside its start/stop window
// - untimed active messages rotate in ascending order when none timed
// - scroll shifts the text one character right every second
// - each message holds sixteen words with own durations
// - word duration is whole seconds, one to sixty
// - scrolling message ignores word durations
// - empty word slots are skipped
// - per-message on-air status while actually sent
// - sixteen af lists, each method a or b
// - af list limit: 25 for method a, 12 for method b
// - method b first entry is the main frequency
// - pi is country, coverage area, broadcaster code in order
// - country and coverage area are four-bit fields
// - broadcaster code is an eight-bit field
// - programme type is a five-bit code
// - decoder identification is a four-bit code
// - traffic programme and traffic announcement flags sent
// - music/speech flag sent
// - remote keyboard lights led, owns flags, pc flag writes ignored
// - host reads back first; nonvolatile commit only on update command
// - serial link defaults to 2400 baud
// - each group carries two station-name characters
`timescale 1ns/1ps
module rcs_top
   import rcs_pkg::*;
(
   input  wire logic          clk_sys_in,
   input  wire logic          reset_in,
   input  wire logic          psel_in,
   input  wire logic          penable_in,
   input  wire logic          pwrite_in,
   input  wire logic [11:0]   paddr_in,
   input  wire logic [31:0]   pwdata_in,
   output logic      [31:0]   prdata_out,
   output logic               pready_out,
   output logic               pslverr_out,
   input  wire logic          sec_tick_in,
   input  wire logic [10:0]   minute_of_day_in,
   input  wire logic          group_req_in,
   input  wire logic          remote_keyboard_present_in,
   input  wire rcs_flags_type kbd_flags_in,
   output logic      [15:0]   ps_chars_out,
   output logic               ps_valid_out,
   output logic      [7:0]    on_air_out,
   output rcs_pi_type         pi_out,
   output logic      [4:0]    pty_out,
   output logic      [3:0]    di_out,
   output rcs_flags_type      flags_out,
   output logic               remote_led_out,
   output logic               nvm_commit_out,
   output logic      [15:0]   baud_div_out
);
   rcs_state_type st;
   rcs_state_type n;

   // content memories; text char 0 sits in the top byte
   logic [63:0] text_mem [NMSG*NWORD];
   logic [5:0]  dur_mem  [NMSG*NWORD];
   logic [7:0]  af_mem   [NAF*AF_MAX_A];

   logic        acc;
   logic        wr;
   logic        mapped;
   logic [31:0] rd;
   logic [8:0]  af_base;
   logic [8:0]  af_addr;
   logic [4:0]  af_lim;
   logic [6:0]  wsel;
   logic [5:0]  dval;
   logic [7:0]  in_win;
   logic [7:0]  hit;
   logic        any_hit;
   logic [2:0]  lo;
   logic [2:0]  nu;
   logic        cur_ok;
   logic [2:0]  tgt;
   logic [3:0]  fw;
   logic [3:0]  nxw;
   logic        adv;
   logic [63:0] w;
   logic [63:0] rot;
   logic [63:0] pick;

   // apb decode and a combinational read mux sampled in setup
   always_comb begin
      acc     = psel_in & penable_in & st.pready;
      wr      = acc & pwrite_in;
      wsel    = {st.wsel_msg, st.wsel_word};
      af_base = 9'(st.afsel_list * 9'(AF_MAX_A));
      af_addr = 9'(af_base + 9'(st.afsel_idx));
      af_lim  = st.af_meth[st.afsel_list] ? 5'(AF_MAX_B)
                                          : 5'(AF_MAX_A);
      // clamp to sixty, zero marks an empty slot
      dval    = (pwdata_in[31:6] != '0 || pwdata_in[5:0] > DUR_MAX)
              ? DUR_MAX : pwdata_in[5:0];
      mapped  = 1'b1;
      rd      = '0;
      if (paddr_in[11:5] == OFS_MSG_CFG[11:5]) begin
         rd[MC_ACT]        = st.cfg[paddr_in[4:2]].message_activate;
         rd[MC_TIMED]      = st.cfg[paddr_in[4:2]].timed;
         rd[MC_SCROLL]     = st.cfg[paddr_in[4:2]].scroll_enable;
         rd[MC_START +: 11] = st.cfg[paddr_in[4:2]].start_min;
         rd[MC_STOP +: 11]  = st.cfg[paddr_in[4:2]].stop_min;
      end else begin
         case (paddr_in)
            OFS_STATUS: begin
               rd[SR_ONAIR +: 8] = st.on_air;
               rd[SR_MSG +: 3]   = st.cur_msg;
               rd[SR_WORD +: 4]  = st.cur_word;
               rd[SR_VALID]      = st.chars_valid;
               rd[SR_REMOTE]     = st.remote;
               rd[SR_DIRTY]      = st.dirty;
            end
            OFS_WSEL: begin
               rd[WS_WORD +: 4] = st.wsel_word;
               rd[WS_MSG +: 3]  = st.wsel_msg;
            end
            OFS_WLO:   rd = text_mem[wsel][63:32];
            OFS_WHI:   rd = text_mem[wsel][31:0];
            OFS_WDUR:  rd[5:0] = dur_mem[wsel];
            OFS_AFSEL: begin
               rd[AS_IDX +: 5]  = st.afsel_idx;
               rd[AS_LIST +: 4] = st.afsel_list;
            end
            OFS_AFDATA: rd[7:0] = af_mem[af_addr];
            OFS_AFCFG: begin
               rd[AC_METH]     = st.af_meth[st.afsel_list];
               rd[AC_CNT +: 5] = st.af_cnt[st.afsel_list];
               // main frequency exists only in method b
               if (st.af_meth[st.afsel_list])
                  rd[AC_MAIN +: 8] = af_mem[af_base];
            end
            OFS_PI:    rd[15:0] = st.pi;
            OFS_PTYDI: begin
               rd[PT_PTY +: 5] = st.pty;
               rd[PT_DI +: 4]  = st.di;
            end
            OFS_FLAGS: rd[2:0] = st.flags;
            OFS_CMD:   rd = '0;
            OFS_BAUD:  rd[15:0] = st.baud_div;
            default:   mapped = 1'b0;
         endcase
      end
   end

   // next state: register file, then scheduler
   always_comb begin
      n        = st;
      n.commit = 1'b0;
      n.rot    = 1'b0;
      // no wait state; read data is flopped during the setup cycle
      n.pready = psel_in & ~penable_in;
      if (psel_in && !penable_in) begin
         n.prdata  = rd;
         n.pslverr = ~mapped;
      end else if (!psel_in) begin
         n.pslverr = 1'b0;
      end
      if (wr && mapped) begin
         if (paddr_in != OFS_CMD)
            n.dirty = 1'b1;
         if (paddr_in[11:5] == OFS_MSG_CFG[11:5]) begin
            n.cfg[paddr_in[4:2]].message_activate = pwdata_in[MC_ACT];
            n.cfg[paddr_in[4:2]].timed            = pwdata_in[MC_TIMED];
            n.cfg[paddr_in[4:2]].scroll_enable    = pwdata_in[MC_SCROLL];
            n.cfg[paddr_in[4:2]].start_min = pwdata_in[MC_START +: 11];
            n.cfg[paddr_in[4:2]].stop_min  = pwdata_in[MC_STOP +: 11];
         end else begin
            case (paddr_in)
               OFS_WSEL: begin
                  n.wsel_word = pwdata_in[WS_WORD +: 4];
                  n.wsel_msg  = pwdata_in[WS_MSG +: 3];
               end
               OFS_AFSEL: begin
                  n.afsel_idx  = pwdata_in[AS_IDX +: 5];
                  n.afsel_list = pwdata_in[AS_LIST +: 4];
               end
               OFS_AFDATA: begin
                  // append grows the list only up to the method limit
                  if (st.afsel_idx == st.af_cnt[st.afsel_list] &&
                      st.af_cnt[st.afsel_list] < af_lim)
                     n.af_cnt[st.afsel_list] =
                        5'(st.af_cnt[st.afsel_list] + 5'h01);
               end
               OFS_AFCFG: begin
                  // method change restarts the list
                  n.af_meth[st.afsel_list] = pwdata_in[AC_METH];
                  n.af_cnt[st.afsel_list]  = '0;
               end
               OFS_PI:    n.pi = pwdata_in[15:0];
               OFS_PTYDI: begin
                  n.pty = pwdata_in[PT_PTY +: 5];
                  n.di  = pwdata_in[PT_DI +: 4];
               end
               OFS_FLAGS: begin
                  if (!remote_keyboard_present_in)
                     n.flags = pwdata_in[2:0];
               end
               OFS_CMD: begin
                  // commit happens only on the explicit update
                  if (pwdata_in[0]) begin
                     n.commit = 1'b1;
                     n.dirty  = 1'b0;
                  end
               end
               OFS_BAUD:  n.baud_div = pwdata_in[15:0];
               default:   ;
            endcase
         end
      end
      // keyboard owns the traffic and music flags
      n.remote = remote_keyboard_present_in;
      if (remote_keyboard_present_in)
         n.flags = kbd_flags_in;

      // timed window per message, wrapping past midnight
      for (int i = 0; i < NMSG; i++) begin
         if (st.cfg[i].start_min <= st.cfg[i].stop_min)
            in_win[i] = minute_of_day_in >= st.cfg[i].start_min &&
                        minute_of_day_in <  st.cfg[i].stop_min;
         else
            in_win[i] = minute_of_day_in >= st.cfg[i].start_min ||
                        minute_of_day_in <  st.cfg[i].stop_min;
         hit[i] = st.cfg[i].message_activate & st.cfg[i].timed &
                  in_win[i];
      end
      any_hit = |hit;
      lo = '0;
      for (int i = NMSG - 1; i >= 0; i--)
         if (hit[i])
            lo = 3'(i);
      // next untimed active message after the current one
      nu = st.cur_msg;
      for (int i = NMSG; i >= 1; i--)
         if (st.cfg[3'(st.cur_msg + 3'(i))].message_activate &&
             !st.cfg[3'(st.cur_msg + 3'(i))].timed)
            nu = 3'(st.cur_msg + 3'(i));
      cur_ok = st.cfg[st.cur_msg].message_activate &&
               !st.cfg[st.cur_msg].timed && !st.rot;
      tgt = any_hit ? lo : (cur_ok ? st.cur_msg : nu);
      // first filled word of the target, next filled word of current
      fw = '0;
      for (int i = NWORD - 1; i >= 0; i--)
         if (dur_mem[{tgt, 4'(i)}] != '0)
            fw = 4'(i);
      nxw = st.cur_word;
      for (int i = NWORD; i >= 1; i--)
         if (dur_mem[{st.cur_msg, 4'(st.cur_word + 4'(i))}] != '0)
            nxw = 4'(st.cur_word + 4'(i));
      adv = 1'b0;
      if (tgt != st.cur_msg) begin
         n.cur_msg    = tgt;
         n.cur_word   = fw;
         n.sec_cnt    = '0;
         n.scroll_pos = '0;
         n.pair       = '0;
      end else if (sec_tick_in) begin
         if (st.cfg[st.cur_msg].scroll_enable) begin
            // durations unused; a full turn moves on a word
            if (st.scroll_pos == 3'(LAST_POS)) begin
               n.scroll_pos = '0;
               adv          = 1'b1;
            end else begin
               n.scroll_pos = 3'(st.scroll_pos + 3'h1);
            end
         end else if (6'(st.sec_cnt + 6'h01) >=
                      dur_mem[{st.cur_msg, st.cur_word}]) begin
            adv = 1'b1;
         end else begin
            n.sec_cnt = 6'(st.sec_cnt + 6'h01);
         end
      end
      if (adv) begin
         n.cur_word = nxw;
         n.sec_cnt  = '0;
         n.pair     = '0;
         // wrap of an untimed message hands over to the next one
         if (nxw <= st.cur_word && !st.cfg[st.cur_msg].timed)
            n.rot = 1'b1;
      end else if (group_req_in) begin
         n.pair = 2'(st.pair + 2'h1);
      end
      // eligibility uses the old window so it matches tgt choice
      n.chars_valid = n.cfg[n.cur_msg].message_activate &&
                      (st.cfg[n.cur_msg].timed ? hit[n.cur_msg]
                                               : !any_hit) &&
                      dur_mem[{n.cur_msg, n.cur_word}] != '0;
      n.on_air = n.chars_valid ? 8'(8'h01 << n.cur_msg) : '0;
      // two characters of the rotated word per group
      w    = text_mem[{st.cur_msg, st.cur_word}];
      rot  = (w >> {st.scroll_pos, 3'b000}) |
             (w << 7'(7'd64 - 7'({st.scroll_pos, 3'b000})));
      pick = rot << {st.pair, 4'b0000};
      n.chars = pick[63:48];
   end

   // state register
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         st          <= '0;
         st.baud_div <= BAUD_DIV;
      end else begin
         st <= n;
      end
   end

   // durations reset to empty so nothing airs before programming
   always_ff @(posedge clk_sys_in or posedge reset_in) begin
      if (reset_in) begin
         for (int i = 0; i < NMSG * NWORD; i++)
            dur_mem[i] <= '0;
      end else if (wr && paddr_in == OFS_WDUR) begin
         dur_mem[wsel] <= dval;
      end
   end

   // text and af contents need no reset
   always_ff @(posedge clk_sys_in) begin
      if (wr && paddr_in == OFS_WLO)
         text_mem[wsel][63:32] <= pwdata_in;
      if (wr && paddr_in == OFS_WHI)
         text_mem[wsel][31:0] <= pwdata_in;
      if (wr && paddr_in == OFS_AFDATA &&
          st.afsel_idx <= st.af_cnt[st.afsel_list] &&
          st.afsel_idx < af_lim)
         af_mem[af_addr] <= pwdata_in[7:0];
   end

   assign prdata_out     = st.prdata;
   assign pready_out     = st.pready;
   assign pslverr_out    = st.pslverr;
   assign ps_chars_out   = st.chars;
   assign ps_valid_out   = st.chars_valid;
   assign on_air_out     = st.on_air;
   assign pi_out         = st.pi;
   assign pty_out        = st.pty;
   assign di_out         = st.di;
   assign flags_out      = st.flags;
   assign remote_led_out = st.remote;
   assign nvm_commit_out = st.commit;
   assign baud_div_out   = st.baud_div;

   // checks
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);

   pick_low_a: assert property (
      any_hit |=> st.cur_msg == $past(lo))
      else $error("timed pick not lowest");
   timed_win_a: assert property (
      n.chars_valid && st.cfg[n.cur_msg].timed |-> in_win[n.cur_msg])
      else $error("timed message outside window");
   untimed_gap_a: assert property (
      any_hit |=> !st.chars_valid || st.cfg[st.cur_msg].timed ||
                  $changed(st.cfg))
      else $error("untimed message during timed period");
   onair_map_a: assert property (
      st.chars_valid |-> st.on_air == 8'(8'h01 << st.cur_msg)
                         && st.cfg[st.cur_msg].message_activate)
      else $error("on air status mismatch");
   skip_empty_a: assert property (
      st.chars_valid && !$past(wr) |-> dur_mem[{st.cur_msg,
                                       st.cur_word}] != '0)
      else $error("empty word sent");
   scroll_hold_a: assert property (
      sec_tick_in && st.chars_valid && !any_hit && !st.rot &&
      st.cfg[st.cur_msg].scroll_enable && !st.cfg[st.cur_msg].timed &&
      st.scroll_pos != 3'(LAST_POS)
      |=> st.cur_word == $past(st.cur_word) &&
          st.scroll_pos == 3'($past(st.scroll_pos) + 3'h1))
      else $error("scroll did not shift");
   af_limit_a: assert property (
      ##1 st.af_cnt[st.afsel_list] <=
          (st.af_meth[st.afsel_list] ? 5'(AF_MAX_B) : 5'(AF_MAX_A)))
      else $error("af list over limit");
   remote_own_a: assert property (
      remote_keyboard_present_in |=> st.flags == $past(kbd_flags_in)
                                     && remote_led_out)
      else $error("remote flags not taken");
   commit_src_a: assert property (
      nvm_commit_out |-> $past(wr && paddr_in == OFS_CMD &&
                               pwdata_in[0]) ##1 !nvm_commit_out)
      else $error("commit without update");
   dur_clamp_a: assert property (
      wr && paddr_in == OFS_WDUR |-> dval <= DUR_MAX)
      else $error("duration above sixty");

   timed_air_c:  cover property (any_hit ##1 st.chars_valid);
   scroll_wrap_c: cover property (sec_tick_in &&
      st.scroll_pos == 3'(LAST_POS) && st.chars_valid);
   rotate_c:     cover property (st.rot ##1 $changed(st.cur_msg));
   remote_c:     cover property ($rose(st.remote));
endmodule : rcs_top

// ---- rtl/rcs_pkg.sv ----
// constants and carrier types for the rds content scheduler
// assumes an apb master, a calendar seconds tick and minute of day
package rcs_pkg;
   localparam int NMSG      = 8;
   localparam int NWORD     = 16;
   localparam int NAF       = 16;
   localparam int AF_MAX_A  = 25;
   localparam int AF_MAX_B  = 12;
   localparam int LAST_POS  = 7;
   localparam logic [5:0] DUR_MAX = 6'h3C;
   // serial link timing
   localparam int CLK_HZ    = 100_000_000;
   localparam int BAUD_RATE = 2400;
   localparam logic [15:0] BAUD_DIV = 16'(CLK_HZ / BAUD_RATE);
   // register byte offsets
   localparam logic [11:0] OFS_MSG_CFG = 12'h000;
   localparam logic [11:0] OFS_STATUS  = 12'h020;
   localparam logic [11:0] OFS_WSEL    = 12'h024;
   localparam logic [11:0] OFS_WLO     = 12'h028;
   localparam logic [11:0] OFS_WHI     = 12'h02C;
   localparam logic [11:0] OFS_WDUR    = 12'h030;
   localparam logic [11:0] OFS_AFSEL   = 12'h034;
   localparam logic [11:0] OFS_AFDATA  = 12'h038;
   localparam logic [11:0] OFS_AFCFG   = 12'h03C;
   localparam logic [11:0] OFS_PI      = 12'h040;
   localparam logic [11:0] OFS_PTYDI   = 12'h044;
   localparam logic [11:0] OFS_FLAGS   = 12'h048;
   localparam logic [11:0] OFS_CMD     = 12'h04C;
   localparam logic [11:0] OFS_BAUD    = 12'h050;
   // field positions
   localparam int MC_ACT = 0, MC_TIMED = 1, MC_SCROLL = 2;
   localparam int MC_START = 8, MC_STOP = 20;
   localparam int SR_ONAIR = 0, SR_MSG = 8, SR_WORD = 11;
   localparam int SR_VALID = 15, SR_REMOTE = 16, SR_DIRTY = 17;
   localparam int WS_WORD = 0, WS_MSG = 4;
   localparam int AS_IDX = 0, AS_LIST = 8;
   localparam int AC_METH = 0, AC_CNT = 8, AC_MAIN = 16;
   localparam int PT_PTY = 0, PT_DI = 8;

   typedef struct packed {
      logic [10:0] stop_min;
      logic [10:0] start_min;
      logic        scroll_enable;
      logic        timed;
      logic        message_activate;
   } rcs_msg_cfg_type;

   typedef struct packed {
      logic [3:0] country;
      logic [3:0] coverage_area_field;
      logic [7:0] code;
   } rcs_pi_type;

   typedef struct packed {
      logic ms;
      logic ta;
      logic tp;
   } rcs_flags_type;

   typedef struct packed {
      rcs_msg_cfg_type [NMSG-1:0] cfg;
      logic [NAF-1:0]             af_meth;
      logic [NAF-1:0][4:0]        af_cnt;
      logic [2:0]                 wsel_msg;
      logic [3:0]                 wsel_word;
      logic [3:0]                 afsel_list;
      logic [4:0]                 afsel_idx;
      rcs_pi_type                 pi;
      logic [4:0]                 pty;
      logic [3:0]                 di;
      rcs_flags_type              flags;
      logic                       remote;
      logic [15:0]                baud_div;
      logic                       dirty;
      logic                       commit;
      logic                       pready;
      logic                       pslverr;
      logic [31:0]                prdata;
      logic [2:0]                 cur_msg;
      logic [3:0]                 cur_word;
      logic [5:0]                 sec_cnt;
      logic [2:0]                 scroll_pos;
      logic [1:0]                 pair;
      logic                       rot;
      logic                       chars_valid;
      logic [7:0]                 on_air;
      logic [15:0]                chars;
   } rcs_state_type;
endpackage : rcs_pkg

// ---- testbench/rcs_far_model.sv ----
// far side of the scheduler: calendar seconds tick and group encoder
// assumes one system clock; minute of day held at midnight
`timescale 1ns/1ps
module rcs_far_model #(
   parameter int TICK = 64
) (
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   input  wire logic        grp_en_in,
   output logic             sec_tick_out,
   output logic             group_req_out,
   output logic [10:0]      minute_out
);
   logic [7:0] cnt_ff;
   // short second so scroll and durations show in a short run
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         cnt_ff        <= 8'h00;
         sec_tick_out  <= 1'b0;
         group_req_out <= 1'b0;
      end else begin
         cnt_ff        <= (cnt_ff == 8'(TICK - 1)) ? 8'h00 : cnt_ff + 8'h01;
         sec_tick_out  <= (cnt_ff == 8'(TICK - 1)); // one pulse
         group_req_out <= grp_en_in && (cnt_ff[3:0] == 4'h0);
      end
   end
   assign minute_out = 11'h000;
endmodule : rcs_far_model

// ---- testbench/tb_top.sv ----
// self-checking bench for the content scheduler over apb
// assumes an apb slave that raises pready when its answer stands
`timescale 1ns/1ps
`define CHK(nm, e, s) begin check_count++; if ((e) !== (s)) begin \
n_mismatch++; $display("wrong value %s exp %h got %h", nm, e, s); end end
module tb_top;
   import rcs_pkg::*;
   logic clk_sys_in = 0, reset_in = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, q;
   logic pready, pslverr, err, tick, greq, grp_en = 0, remote_keyboard_present = 0, seen = 0;
   logic [10:0] minute;
   rcs_flags_type kbd = 3'b000, flags;
   rcs_pi_type pi;
   logic [15:0] chars, baud;
   logic [7:0] on_air;
   logic [4:0] pty;
   logic [3:0] di;
   logic ps_valid, led, commit;
   int n_mismatch = 0, check_count = 0, cyc = 0;
   rcs_top rcs_top_inst (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .sec_tick_in(tick),
      .minute_of_day_in(minute), .group_req_in(greq),
      .remote_keyboard_present_in(remote_keyboard_present), .kbd_flags_in(kbd),
      .ps_chars_out(chars), .ps_valid_out(ps_valid), .on_air_out(on_air),
      .pi_out(pi), .pty_out(pty), .di_out(di), .flags_out(flags),
      .remote_led_out(led), .nvm_commit_out(commit), .baud_div_out(baud));
   rcs_far_model rcs_far_model_inst (.clk_in(clk_sys_in),
      .reset_in(reset_in), .grp_en_in(grp_en), .sec_tick_out(tick),
      .group_req_out(greq), .minute_out(minute));
   initial begin
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   // sticky capture: the commit pulse lasts one cycle only
   always @(posedge clk_sys_in) begin
      cyc <= cyc + 1;
      if (commit === 1'b1) seen <= 1'b1;
      if (cyc == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   // one apb transfer; request held until pready seen high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk_sys_in);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys_in);
      penable <= 1;
      // no timeout here; only the bench cycle limit ends a hung wait
      do begin
         @(posedge clk_sys_in);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
   endtask : apb
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask : wait_cyc
   task automatic t_ident();
      `CHK("baud", 16'hA2C2, baud)
      apb(1, OFS_PI, 32'h0000_5A3C);
      apb(1, OFS_PTYDI, 32'h0000_0F1F);
      wait_cyc(3);
      `CHK("pi", 16'h5A3C, pi)
      `CHK("pty", 5'h1F, pty)
      `CHK("di", 4'hF, di)
      apb(0, 12'hFFC, 32'h0000_0000);
      `CHK("unmapped", 1'b1, err)
      $display("ident test done");
   endtask : t_ident
   task automatic t_flags();
      apb(1, OFS_FLAGS, 32'h0000_0005);
      wait_cyc(3);
      `CHK("pc flags", 3'b101, flags)
      @(posedge clk_sys_in);
      remote_keyboard_present <= 1;
      kbd <= 3'b010;
      apb(1, OFS_FLAGS, 32'h0000_0007);
      wait_cyc(3);
      `CHK("kbd flags", 3'b010, flags)
      `CHK("led", 1'b1, led)
      @(posedge clk_sys_in);
      remote_keyboard_present <= 0;
      wait_cyc(3);
      `CHK("pc ignored", 3'b010, flags)
      `CHK("led off", 1'b0, led)
      $display("flags test done");
   endtask : t_flags
   task automatic t_msg();
      apb(1, OFS_WSEL, 32'h0000_0000);
      apb(1, OFS_WLO, 32'h4142_4344);
      apb(1, OFS_WHI, 32'h4546_4748);
      apb(1, OFS_WDUR, 32'h0000_0045);
      apb(0, OFS_WDUR, 32'h0000_0000);
      `CHK("dur clamp", 32'h0000_003C, q)
      `CHK("idle", 8'h00, on_air)
      apb(1, OFS_MSG_CFG, 32'h0000_0001);
      wait_cyc(3);
      `CHK("on air", 8'h01, on_air)
      `CHK("valid", 1'b1, ps_valid)
      `CHK("chars", 16'h4142, chars)
      apb(0, OFS_STATUS, 32'h0000_0000);
      `CHK("status", 1'b1, q[SR_ONAIR])
      `CHK("dirty", 1'b1, q[SR_DIRTY])
      $display("message test done");
   endtask : t_msg
   // one group request, then one scroll step of the untimed message
   task automatic t_scroll();
      @(posedge clk_sys_in);
      grp_en <= 1;
      do begin
         @(posedge clk_sys_in);
      end while (greq !== 1'b1);
      grp_en <= 0;
      wait_cyc(2);
      `CHK("pair 1", 16'h4344, chars)
      apb(1, OFS_MSG_CFG, 32'h0000_0005);
      do begin
         @(posedge clk_sys_in);
      end while (tick !== 1'b1);
      wait_cyc(2);
      `CHK("scroll 1", 16'h4243, chars)
      $display("group and scroll test done");
   endtask : t_scroll
   // timed messages in window at minute zero take over
   task automatic t_timed();
      apb(1, OFS_WSEL, 32'h0000_0020);
      apb(1, OFS_WDUR, 32'h0000_0001);
      apb(1, OFS_MSG_CFG + 12'h008, 32'h0010_0003);
      wait_cyc(3);
      `CHK("timed on air", 8'h04, on_air)
      apb(1, OFS_WSEL, 32'h0000_0010);
      apb(1, OFS_WDUR, 32'h0000_0001);
      apb(1, OFS_MSG_CFG + 12'h004, 32'h0010_0003);
      wait_cyc(3);
      `CHK("lowest timed", 8'h02, on_air)
      $display("timed test done");
   endtask : t_timed
   task automatic t_af();
      apb(1, OFS_AFSEL, 32'h0000_0100);
      apb(1, OFS_AFCFG, 32'h0000_0001);
      for (int i = 0; i < 13; i++) begin
         apb(1, OFS_AFSEL, 32'h0000_0100 | i);
         apb(1, OFS_AFDATA, 32'(10 + i));
      end
      apb(0, OFS_AFCFG, 32'h0000_0000);
      `CHK("af list b", 32'h000A_0C01, q)
      `CHK("no commit", 1'b0, seen)
      apb(1, OFS_CMD, 32'h0000_0001);
      wait_cyc(3);
      `CHK("commit", 1'b1, seen)
      apb(0, OFS_STATUS, 32'h0000_0000);
      `CHK("clean", 1'b0, q[SR_DIRTY])
      $display("af and commit test done");
   endtask : t_af
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (20) @(posedge clk_sys_in);
      reset_in <= 0;
      wait_cyc(1);
      t_ident();
      t_flags();
      t_msg();
      t_scroll();
      t_timed();
      t_af();
      report_and_stop();
   end
endmodule : tb_top
